// File: hmt_pkg.sv
/*
 * Constants, types and field layout for the haptic mode and trigger control block.
 * Assumes a register port decoded by the serial host interface ahead of this block.
 */
// Functional notes
// - Writing 1 to mode bit 7 performs a full power-cycle equivalent reset.
// - Soft reset aborts playback at once and restores every register default.
// - The soft reset bit clears itself when the reset operation ends.
// - Mode bit 6 is standby, 1 standby, 0 ready; resets to 1.
// - Mode 0: playback starts only when the host sets the launch flag.
// - Mode 1: a rising trigger edge sets the launch flag.
// - Mode 1: a second rising edge before the flag clears cancels playback.
// - Mode 2: the launch flag follows the trigger; a rising edge sets it.
// - Mode 2: a falling trigger edge cancels current playback.
// - Mode 2: if the flag already matches the edge, nothing changes.
// - Mode 3: the trigger pin carries a PWM or analog drive source.
// - Mode 3: the actuator is driven the whole time the mode is selected and standby is 0, except while a soft clear runs.
// - Mode 3: the source select bit picks PWM or analog interpretation.
// - Mode 5: the actuator is driven continuously from the realtime drive value.
// - The device clears the launch flag when the diagnostic completes.
// - The diagnostic outcome is written to the test outcome flag in status.
// - The device clears the launch flag when auto calibration ends.
// - Test outcome holds the last calibration or diagnostic result; clears on read.
// - Test outcome 0 means converged or normal, 1 means failure or fault.

package hmt_pkg;

   // =========================================================================
   // Register offsets
   // =========================================================================
   localparam logic [7:0] OFS_STATUS     = 8'h00;
   localparam logic [7:0] OFS_MODE       = 8'h01;
   localparam logic [7:0] OFS_REALTIME   = 8'h02;
   localparam logic [7:0] OFS_LAUNCH     = 8'h0c;
   localparam logic [7:0] OFS_SRC_SELECT = 8'h1e;

   // =========================================================================
   // Field positions
   // =========================================================================
   localparam int MODE_RESET_BIT   = 7;
   localparam int MODE_STANDBY_BIT = 6;
   localparam int MODE_FIELD_LSB   = 0;
   localparam int MODE_FIELD_W     = 3;
   localparam int STAT_ID_LSB      = 5;
   localparam int STAT_OUTCOME_BIT = 3;
   localparam int LAUNCH_BIT       = 0;
   localparam int SRC_ANALOG_BIT   = 0;

   // =========================================================================
   // Reset values
   // =========================================================================
   localparam logic             STANDBY_RST  = 1'b1;
   localparam logic [2:0]       MODE_RST     = 3'h0;
   localparam logic [7:0]       REALTIME_RST = 8'h00;
   localparam logic             SRC_SEL_RST  = 1'b0;
   // Identifier value is arbitrary.
   localparam logic [2:0]       DEVICE_ID_VAL = 3'h1;

   // =========================================================================
   // Timing
   // =========================================================================
   localparam int CLK_PERIOD_NS      = 100;
   localparam int SOFT_RESET_TIME_NS = 1000;
   localparam int SOFT_RESET_CYCLES  =
      (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SRST_CNT_W         = 4;

   // =========================================================================
   // Types
   // =========================================================================
   typedef enum logic [2:0]
   {
      MODE_INTERNAL = 3'h0,
      MODE_EDGE     = 3'h1,
      MODE_LEVEL    = 3'h2,
      MODE_PWM_AN   = 3'h3,
      MODE_RSVD     = 3'h4,
      MODE_REALTIME = 3'h5,
      MODE_DIAG     = 3'h6,
      MODE_CAL      = 3'h7
   } hmt_mode_t;

   typedef enum logic [2:0]
   {
      SRC_IDLE,
      SRC_SEQUENCER,
      SRC_PWM,
      SRC_ANALOG,
      SRC_REALTIME,
      SRC_DIAG,
      SRC_CAL
   } hmt_src_t;

   typedef struct packed
   {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hmt_reg_req_t;

   typedef struct packed
   {
      logic wave_done;
      logic test_done;
      logic test_fail;
   } hmt_engine_stat_t;

   typedef struct packed
   {
      logic     start;
      logic     cancel;
      hmt_src_t source;
      logic     drive_on;
   } hmt_engine_ctl_t;

endpackage : hmt_pkg

// File: hmt_pin_sync.sv
/*
 * Three-stage synchroniser with edge detection for the trigger pin.
 * Assumes an asynchronous pin; a level counts once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none

module hmt_pin_sync
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       level_reg;
   logic       level_next;
   logic       rise_reg;
   logic       rise_next;
   logic       fall_reg;
   logic       fall_next;

   // =========================================================================
   // Next state
   // =========================================================================
   // Stage 0 feeds stage 1 only; the filter reads stages 1 and 2.
   always_comb
   begin
      sync_next  = {sync_reg[1:0], pin_in};
      level_next = level_reg;
      rise_next  = 1'b0;
      fall_next  = 1'b0;
      if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg)
      begin
         level_next = sync_reg[2];
         rise_next  = sync_reg[2];
         fall_next  = ~sync_reg[2];
      end
   end

   // =========================================================================
   // Registers
   // =========================================================================
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync_reg  <= 3'h0;
         level_reg <= 1'b0;
         rise_reg  <= 1'b0;
         fall_reg  <= 1'b0;
      end
      else
      begin
         sync_reg  <= sync_next;
         level_reg <= level_next;
         rise_reg  <= rise_next;
         fall_reg  <= fall_next;
      end
   end

   assign level = level_reg;
   assign rise  = rise_reg;
   assign fall  = fall_reg;

endmodule : hmt_pin_sync

`default_nettype wire

// File: hmt_soft_reset.sv
/*
 * Soft reset sequencer: holds an internal clear for a fixed number of cycles.
 * Assumes a one-cycle request pulse from the register decoder.
 */
`timescale 1ns/1ps
`default_nettype none

module hmt_soft_reset
   import hmt_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic request,
   output logic      active
);

   logic [SRST_CNT_W-1:0] cnt_reg;
   logic [SRST_CNT_W-1:0] cnt_next;
   logic                  active_reg;
   logic                  active_next;

   // =========================================================================
   // Next state
   // =========================================================================
   // A request during an ongoing reset restarts nothing; the clear is already running.
   always_comb
   begin
      cnt_next    = cnt_reg;
      active_next = active_reg;
      if (active_reg)
      begin
         if (cnt_reg == SRST_CNT_W'(SOFT_RESET_CYCLES - 1))
         begin
            active_next = 1'b0;
            cnt_next    = '0;
         end
         else
         begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
      else if (request)
      begin
         active_next = 1'b1;
         cnt_next    = '0;
      end
   end

   // =========================================================================
   // Registers
   // =========================================================================
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_reg    <= '0;
         active_reg <= 1'b0;
      end
      else
      begin
         cnt_reg    <= cnt_next;
         active_reg <= active_next;
      end
   end

   assign active = active_reg;

endmodule : hmt_soft_reset

`default_nettype wire

// File: hmt_mode_trigger_control.sv
/*
 * Mode control register and launch flag logic of a haptic actuator driver.
 * Assumes a decoded byte register port from the serial host interface, a playback
 * engine that reports waveform and test completion, and a raw trigger pin.
 */
`timescale 1ns/1ps
`default_nettype none

module hmt_mode_trigger_control
(
   input  wire logic                      clk,
   input  wire logic                      rst,
   input  wire hmt_pkg::hmt_reg_req_t     reg_req,
   output logic [7:0]                     reg_rdata,
   input  wire logic                      trigger_input_pin,
   input  wire hmt_pkg::hmt_engine_stat_t engine_stat,
   output hmt_pkg::hmt_engine_ctl_t       engine_ctl,
   output logic [7:0]                     realtime_drive_value,
   output logic                           standby,
   output logic                           launch_flag,
   output logic                           soft_reset_busy
);
   import hmt_pkg::*;

   // =========================================================================
   // Declarations
   // =========================================================================
   logic            trig_level;
   logic            trig_rise;
   logic            trig_fall;
   logic            srst_req;
   logic            srst_active;

   logic            standby_reg;
   logic            standby_next;
   hmt_mode_t       mode_reg;
   hmt_mode_t       mode_next;
   logic [7:0]      rt_reg;
   logic [7:0]      rt_next;
   logic            src_sel_reg;
   logic            src_sel_next;
   logic            go_reg;
   logic            go_next;
   logic            outcome_reg;
   logic            outcome_next;
   logic [7:0]      rdata_reg;
   logic [7:0]      rdata_next;
   hmt_engine_ctl_t ctl_reg;
   hmt_engine_ctl_t ctl_next;
   logic            srst_out_reg;

   logic            wr_mode;
   logic            wr_go;
   logic            host_set;
   logic            host_clear;
   logic            trig_mode;

   // =========================================================================
   // Submodules
   // =========================================================================
   hmt_pin_sync u_trig_sync
   (
      .clk    (clk),
      .rst    (rst),
      .pin_in (trigger_input_pin),
      .level  (trig_level),
      .rise   (trig_rise),
      .fall   (trig_fall)
   );

   // A soft reset request is taken only when no clear is running.
   assign srst_req = wr_mode && reg_req.wdata[MODE_RESET_BIT];

   hmt_soft_reset u_soft_reset
   (
      .clk     (clk),
      .rst     (rst),
      .request (srst_req),
      .active  (srst_active)
   );

   // =========================================================================
   // Write decode
   // =========================================================================
   // Writes are ignored while the soft clear runs, so the defaults cannot be overwritten.
   assign wr_mode    = reg_req.wr && !srst_active && reg_req.addr == OFS_MODE;
   assign wr_go      = reg_req.wr && !srst_active && reg_req.addr == OFS_LAUNCH;
   assign host_set   = wr_go && reg_req.wdata[LAUNCH_BIT];
   assign host_clear = wr_go && !reg_req.wdata[LAUNCH_BIT];
   assign trig_mode  = mode_reg == MODE_INTERNAL || mode_reg == MODE_EDGE || mode_reg == MODE_LEVEL;

   // =========================================================================
   // Configuration registers
   // =========================================================================
   // A write with the reset bit set only launches the clear; its other bits are dropped.
   always_comb
   begin
      standby_next = standby_reg;
      mode_next    = mode_reg;
      rt_next      = rt_reg;
      src_sel_next = src_sel_reg;
      if (srst_active)
      begin
         standby_next = STANDBY_RST;
         mode_next    = hmt_mode_t'(MODE_RST);
         rt_next      = REALTIME_RST;
         src_sel_next = SRC_SEL_RST;
      end
      else if (wr_mode && !reg_req.wdata[MODE_RESET_BIT])
      begin
         standby_next = reg_req.wdata[MODE_STANDBY_BIT];
         mode_next    = hmt_mode_t'(reg_req.wdata[MODE_FIELD_LSB +: MODE_FIELD_W]);
      end
      else if (reg_req.wr && reg_req.addr == OFS_REALTIME)
      begin
         rt_next = reg_req.wdata;
      end
      else if (reg_req.wr && reg_req.addr == OFS_SRC_SELECT)
      begin
         src_sel_next = reg_req.wdata[SRC_ANALOG_BIT];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         standby_reg <= STANDBY_RST;
         mode_reg    <= MODE_INTERNAL;
         rt_reg      <= REALTIME_RST;
         src_sel_reg <= SRC_SEL_RST;
      end
      else
      begin
         standby_reg <= standby_next;
         mode_reg    <= mode_next;
         rt_reg      <= rt_next;
         src_sel_reg <= src_sel_next;
      end
   end

   // =========================================================================
   // Launch flag, test outcome and engine commands
   // =========================================================================
   // Hardware sets win over host clears, so a trigger edge in the clear cycle survives.
   always_comb
   begin
      go_next         = go_reg;
      outcome_next    = outcome_reg;
      ctl_next        = ctl_reg;
      ctl_next.start  = 1'b0;
      ctl_next.cancel = 1'b0;
      if (srst_active)
      begin
         go_next         = 1'b0;
         outcome_next    = 1'b0;
         ctl_next.cancel = go_reg;
      end
      else
      begin
         // Completion events from the engine.
         if (go_reg && trig_mode && engine_stat.wave_done)
         begin
            go_next = 1'b0;
         end
         if (go_reg && (mode_reg == MODE_DIAG || mode_reg == MODE_CAL) && engine_stat.test_done)
         begin
            go_next = 1'b0;
         end
         if (host_clear && go_reg)
         begin
            go_next         = 1'b0;
            ctl_next.cancel = 1'b1;
         end
         // Host launch works in internal, diagnostic and calibration modes.
         if (host_set && !go_reg && !standby_reg &&
             (mode_reg == MODE_INTERNAL || mode_reg == MODE_DIAG || mode_reg == MODE_CAL))
         begin
            go_next        = 1'b1;
            ctl_next.start = 1'b1;
         end
         // Pin triggers are only honoured when out of standby.
         if (!standby_reg && mode_reg == MODE_EDGE && trig_rise)
         begin
            if (go_reg && !engine_stat.wave_done)
            begin
               go_next         = 1'b0;
               ctl_next.cancel = 1'b1;
            end
            else
            begin
               go_next        = 1'b1;
               ctl_next.start = 1'b1;
            end
         end
         if (!standby_reg && mode_reg == MODE_LEVEL)
         begin
            if (trig_rise && !go_reg)
            begin
               go_next        = 1'b1;
               ctl_next.start = 1'b1;
            end
            else if (trig_fall && go_reg)
            begin
               go_next         = 1'b0;
               ctl_next.cancel = 1'b1;
            end
         end
         // Test outcome: read clears it, a finishing test loads its fail result and wins.
         if (reg_req.rd && reg_req.addr == OFS_STATUS)
         begin
            outcome_next = 1'b0;
         end
         if (go_reg && (mode_reg == MODE_DIAG || mode_reg == MODE_CAL) && engine_stat.test_done)
         begin
            outcome_next = engine_stat.test_fail;
         end
      end
      // Drive source selection; continuous modes drive while selected, out of standby and outside a soft clear.
      ctl_next.drive_on = 1'b0;
      ctl_next.source   = SRC_IDLE;
      if (!srst_active && !standby_reg)
      begin
         case (mode_reg)
            MODE_INTERNAL, MODE_EDGE, MODE_LEVEL:
            begin
               ctl_next.source   = SRC_SEQUENCER;
               ctl_next.drive_on = go_next;
            end
            MODE_PWM_AN:
            begin
               ctl_next.source   = src_sel_reg ? SRC_ANALOG : SRC_PWM;
               ctl_next.drive_on = 1'b1;
            end
            MODE_REALTIME:
            begin
               ctl_next.source   = SRC_REALTIME;
               ctl_next.drive_on = 1'b1;
            end
            MODE_DIAG:
            begin
               ctl_next.source   = SRC_DIAG;
               ctl_next.drive_on = go_next;
            end
            MODE_CAL:
            begin
               ctl_next.source   = SRC_CAL;
               ctl_next.drive_on = go_next;
            end
            default:
            begin
               ctl_next.source   = SRC_IDLE;
               ctl_next.drive_on = 1'b0;
            end
         endcase
      end
   end

   // =========================================================================
   // Read data
   // =========================================================================
   // Reserved bits read as zero; the reset bit reads 1 while the clear runs.
   always_comb
   begin
      rdata_next = rdata_reg;
      if (reg_req.rd)
      begin
         case (reg_req.addr)
            OFS_STATUS:     rdata_next = {DEVICE_ID_VAL, 1'b0, outcome_reg, 3'h0};
            OFS_MODE:       rdata_next = {srst_active, standby_reg, 3'h0, mode_reg};
            OFS_REALTIME:   rdata_next = rt_reg;
            OFS_LAUNCH:     rdata_next = {7'h00, go_reg};
            OFS_SRC_SELECT: rdata_next = {7'h00, src_sel_reg};
            default:        rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         go_reg       <= 1'b0;
         outcome_reg  <= 1'b0;
         ctl_reg      <= '{start: 1'b0, cancel: 1'b0, source: SRC_IDLE, drive_on: 1'b0};
         rdata_reg    <= 8'h00;
         srst_out_reg <= 1'b0;
      end
      else
      begin
         go_reg       <= go_next;
         outcome_reg  <= outcome_next;
         ctl_reg      <= ctl_next;
         rdata_reg    <= rdata_next;
         srst_out_reg <= srst_active;
      end
   end

   // =========================================================================
   // Outputs
   // =========================================================================
   // The trigger level is unused; only its rise and fall pulses feed the launch flag path.
   assign reg_rdata            = rdata_reg;
   assign engine_ctl           = ctl_reg;
   assign realtime_drive_value = rt_reg;
   assign standby              = standby_reg;
   assign launch_flag          = go_reg;
   assign soft_reset_busy      = srst_out_reg;

   logic unused_level;
   assign unused_level = trig_level;

endmodule : hmt_mode_trigger_control

`default_nettype wire

// File: hmt_mtc_monitor.sv
/* Checker for the mode and trigger control block.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module hmt_mtc_monitor
(
   input wire logic                      clk,
   input wire logic                      rst,
   input wire hmt_pkg::hmt_reg_req_t     reg_req,
   input wire logic [7:0]                reg_rdata,
   input wire logic                      trigger_input_pin,
   input wire hmt_pkg::hmt_engine_stat_t engine_stat,
   input wire hmt_pkg::hmt_engine_ctl_t  engine_ctl,
   input wire logic [7:0]                realtime_drive_value,
   input wire logic                      standby,
   input wire logic                      launch_flag,
   input wire logic                      soft_reset_busy
);
   import hmt_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Writes just after a soft reset request fall in the clear, so they are not judged.
   logic [1:0] srq_reg;
   wire logic  wr_ok = reg_req.wr && !soft_reset_busy && srq_reg == 2'h0;
   always_ff @(posedge clk or posedge rst)
      if (rst) srq_reg <= 2'h0;
      else srq_reg <= {srq_reg[0], reg_req.wr && reg_req.addr == OFS_MODE && reg_req.wdata[7]};
   sequence s_srst_req;
      wr_ok && reg_req.addr == OFS_MODE && reg_req.wdata[7];
   endsequence
   sequence s_busy_ends;
      soft_reset_busy ##[1:12] !soft_reset_busy;
   endsequence
   // =====
   // Assertions
   a_reset_starts:
   assert property (s_srst_req |-> ##[1:3] soft_reset_busy) else $error("soft reset did not start");
   a_reset_ends:
   assert property ($rose(soft_reset_busy) |-> s_busy_ends) else $error("soft reset did not end");
   a_reset_defaults:
   assert property ($fell(soft_reset_busy) |-> standby && !launch_flag && realtime_drive_value == REALTIME_RST)
      else $error("registers not at defaults after soft reset");
   a_standby_write:
   assert property (wr_ok && reg_req.addr == OFS_MODE && !reg_req.wdata[7] |=> standby == $past(reg_req.wdata[6]))
      else $error("standby bit not written");
   a_rt_write:
   assert property (wr_ok && reg_req.addr == OFS_REALTIME |=> realtime_drive_value == $past(reg_req.wdata))
      else $error("realtime value not written");
   a_start_launch:
   assert property ($rose(launch_flag) |-> engine_ctl.start) else $error("launch without start");
   a_cancel_drop:
   assert property (engine_ctl.cancel |-> !launch_flag) else $error("cancel with launch flag set");
   a_rsvd_zero:
   assert property (reg_req.rd && reg_req.addr == OFS_MODE |=> reg_rdata[5:3] == 3'h0)
      else $error("reserved mode bits not zero");
endmodule : hmt_mtc_monitor
bind hmt_mode_trigger_control hmt_mtc_monitor hmt_mtc_monitor_i (.clk(clk), .rst(rst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .trigger_input_pin(trigger_input_pin), .engine_stat(engine_stat),
   .engine_ctl(engine_ctl), .realtime_drive_value(realtime_drive_value), .standby(standby),
   .launch_flag(launch_flag), .soft_reset_busy(soft_reset_busy));
`default_nettype wire

// File: hmt_engine_model.sv
/* Playback engine stand-in answering start and cancel.
   Assumes the testbench sets the answer delay and the test outcome. */
`timescale 1ns/1ps
`default_nettype none
module hmt_engine_model
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire hmt_pkg::hmt_engine_ctl_t ctl,
   input  wire logic [7:0]               dly,
   input  wire logic                     fail,
   output var hmt_pkg::hmt_engine_stat_t stat
);
   import hmt_pkg::*;
   logic [7:0] cnt;
   // A cancel drops the job at once; a long delay lets the bench cancel in flight.
   always_ff @(posedge clk or posedge rst)
   begin
      stat <= '0;
      if (rst)
         cnt <= 8'h00;
      else if (ctl.cancel)
         cnt <= 8'h00;
      else if (ctl.start)
         cnt <= dly;
      else if (cnt == 8'h01)
      begin
         cnt <= 8'h00;
         stat.wave_done <= !(ctl.source inside {SRC_DIAG, SRC_CAL});
         stat.test_done <= ctl.source inside {SRC_DIAG, SRC_CAL};
         stat.test_fail <= fail;
      end
      else if (cnt != 8'h00)
         cnt <= cnt - 8'h01;
   end
endmodule : hmt_engine_model
`default_nettype wire

// File: hmt_mode_trigger_control_tb_top.sv
/* Self-checking testbench for the mode and trigger control block.
   Assumes the engine model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module hmt_mode_trigger_control_tb_top;
   import hmt_pkg::*;
   logic             clk, rst, pin, fail, stby, launch, busy;
   logic [7:0]       dly, rdata, rt;
   hmt_reg_req_t     req;
   hmt_engine_stat_t stat;
   hmt_engine_ctl_t  ctl;
   int               bad_count = 0;
   int               n_tests = 0;
   hmt_mode_trigger_control hmt_mode_trigger_control_i (.clk(clk), .rst(rst), .reg_req(req), .reg_rdata(rdata),
      .trigger_input_pin(pin), .engine_stat(stat), .engine_ctl(ctl), .realtime_drive_value(rt),
      .standby(stby), .launch_flag(launch), .soft_reset_busy(busy));
   hmt_engine_model hmt_engine_model_i (.clk(clk), .rst(rst), .ctl(ctl), .dly(dly), .fail(fail), .stat(stat));
   // =====
   // Shared tasks
   task test_done;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Inputs change 1 ns after the edge so the design samples settled values.
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // Each access leaves an idle cycle so the strobe is never set twice in one step.
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      req = '{wr: w, rd: !w, addr: a, wdata: d};
      cyc(1);
      req = '0;
      cyc(1);
   endtask : acc
   task rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(rdata, exp);
   endtask : rd
   task wl(input logic v);
      for (int i = 0; i < 300 && launch !== v; i++)
         cyc(1);
      chk({7'h00, launch}, {7'h00, v});
      if (launch !== v)
         test_done();
   endtask : wl
   // =====
   // Scenarios
   task t_internal;
      rd(OFS_MODE, 8'h40);
      acc(1'b1, OFS_MODE, 8'h38);
      rd(OFS_MODE, 8'h00);
      cyc(4);
      chk({7'h00, launch}, 8'h00);
      acc(1'b1, OFS_LAUNCH, 8'h01);
      chk({7'h00, launch}, 8'h01);
      wl(1'b0);
      $display("internal launch done");
   endtask : t_internal
   task t_trigger;
      dly = 8'd200;
      acc(1'b1, OFS_MODE, 8'h01);
      pin = 1'b1;
      wl(1'b1);
      pin = 1'b0;
      cyc(3);
      pin = 1'b1;
      wl(1'b0);
      // Level mode acts on edges only, so the pin is lowered first and raised once the mode is set.
      pin = 1'b0;
      cyc(4);
      acc(1'b1, OFS_MODE, 8'h02);
      pin = 1'b1;
      wl(1'b1);
      pin = 1'b0;
      wl(1'b0);
      $display("trigger modes done");
   endtask : t_trigger
   task t_test(input logic [7:0] m, input logic f);
      dly = 8'd30;
      fail = f;
      acc(1'b1, OFS_MODE, m);
      acc(1'b1, OFS_LAUNCH, 8'h01);
      wl(1'b0);
      rd(OFS_STATUS, {DEVICE_ID_VAL, 1'b0, f, 3'h0});
      rd(OFS_STATUS, {DEVICE_ID_VAL, 5'h00});
      $display("test mode done");
   endtask : t_test
   task t_drive;
      acc(1'b1, OFS_MODE, 8'h03);
      chk({ctl.drive_on, 4'h0, ctl.source}, {1'b1, 4'h0, SRC_PWM});
      acc(1'b1, OFS_SRC_SELECT, 8'h01);
      chk({ctl.drive_on, 4'h0, ctl.source}, {1'b1, 4'h0, SRC_ANALOG});
      acc(1'b1, OFS_REALTIME, 8'ha5);
      acc(1'b1, OFS_MODE, 8'h05);
      chk({ctl.drive_on, 4'h0, ctl.source}, {1'b1, 4'h0, SRC_REALTIME});
      chk(rt, 8'ha5);
      acc(1'b1, OFS_MODE, 8'h04);
      chk({7'h00, ctl.drive_on}, 8'h00);
      $display("drive modes done");
   endtask : t_drive
   task t_soft;
      acc(1'b1, OFS_MODE, 8'h01);
      pin = 1'b1;
      wl(1'b1);
      acc(1'b1, OFS_MODE, 8'h80);
      chk({7'h00, launch}, 8'h00);
      cyc(SOFT_RESET_CYCLES + 2);
      rd(OFS_MODE, 8'h40);
      rd(OFS_REALTIME, 8'h00);
      $display("soft reset done");
   endtask : t_soft
   // =====
   // Clock and main sequence
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      {rst, pin, fail, dly, req} = {1'b1, 1'b0, 1'b0, 8'd20, 18'h0};
      cyc(5);
      rst = 1'b0;
      t_internal();
      t_trigger();
      t_test(8'h06, 1'b1);
      t_test(8'h07, 1'b0);
      t_drive();
      t_soft();
      test_done();
   end
endmodule : hmt_mode_trigger_control_tb_top
`default_nettype wire
